/* File: design/ppt_top.sv */
/*
  ppt_top: supply pin over-current protection, adc trigger routing from
  pwm channels five and four, and high-voltage input open-input test.
  assumes: pins and pwm flags are synchronous to i_clk, the over-current
  comparator and pad levels arrive already synchronised.
*/
`timescale 1ns/10ps

// Functional notes
// - trigger inputs follow pwm channels five, four
// - relocated pwm channel moves trigger pin too
// - enabled external pwm drives trigger, else pin
// - monitor powered only while enable bit set
// - protection only with full drive, high output
// - monitor off during stop mode
// - over-current forces driver low, sets flag
// - override keeps digital buffer alive in analog, unless direct input selected
// - pull select one pullup, zero pulldown
// - pullup: external pulldown reads 0, open 1
// - pulldown: external pullup reads 1, open 0
// - flag interrupts only while enable set
// - driver forced low until flag cleared
// - analog run mode disables selected digital buffer
module ppt_top #(
    parameter int HV_PINS = 4
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire ppt_pkg::ppt_reg_req_t i_req,
    output logic [7:0] o_rdata,
    input wire logic i_stop_mode,
    input wire logic i_oc_detect,
    input wire logic i_pwm_supply_en,
    input wire logic i_pwm_supply_val,
    input wire logic [1:0] i_pwm_val,
    input wire ppt_pkg::ppt_pwm_route_t [1:0] i_pwm_route,
    input wire logic [1:0] i_pin_main,
    input wire logic [1:0] i_pin_alt,
    input wire logic [HV_PINS-1:0] i_hv_pad,
    output logic o_supply_drive,
    output logic o_supply_full_drive,
    output logic o_oc_monitor_on,
    output logic [1:0] o_adc_ext_trigger_in,
    output logic [HV_PINS-1:0] o_hv_buffer_en,
    output logic [HV_PINS-1:0] o_hv_pullup_en,
    output logic [HV_PINS-1:0] o_hv_pulldown_en,
    output logic o_irq
);

    logic [7:0] misc_reg;        // port_misc_config
    logic [7:0] out_reg;         // pin_output_value_reg
    logic [7:0] hv_reg;          // hv_analog_control
    logic [7:0] irq_en_reg;      // port_p_irq_enables
    logic [7:0] trig_reg;        // spare routing bits, read back only
    logic oc_flag_reg;           // overcurrent_flag
    logic [HV_PINS-1:0] level_reg;  // hv_input_level
    logic [7:0] rdata_next;
    logic oc_clr;
    logic monitor_on;
    logic supply_high;
    logic [1:0] hv_sel;
    logic [HV_PINS-1:0] buf_en_next;

    // hv_pin_select: two bits upward from its field position
    assign hv_sel = hv_reg[ppt_pkg::PPT_HV_SEL_LSB +: 2];

    // software-visible register writes
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            misc_reg <= ppt_pkg::PPT_MISC_RST;
            out_reg <= ppt_pkg::PPT_OUT_RST;
            hv_reg <= ppt_pkg::PPT_HV_RST;
            irq_en_reg <= ppt_pkg::PPT_IRQ_EN_RST;
            trig_reg <= ppt_pkg::PPT_TRIG_RST;
        end
        else if (i_req.wr)
        begin
            unique case (i_req.addr)
                ppt_pkg::PPT_ADDR_MISC: misc_reg <= i_req.wdata;
                ppt_pkg::PPT_ADDR_OUT: out_reg <= i_req.wdata;
                ppt_pkg::PPT_ADDR_HV: hv_reg <= i_req.wdata;
                ppt_pkg::PPT_ADDR_IRQ_EN: irq_en_reg <= i_req.wdata;
                ppt_pkg::PPT_ADDR_TRIG: trig_reg <= i_req.wdata;
                // read-only and clear addresses store nothing here
                default: ;
            endcase
        end
    end

    // write one to the clear register drops the flag
    assign oc_clr = i_req.wr && (i_req.addr == ppt_pkg::PPT_ADDR_IRQ_CLR)
        && i_req.wdata[ppt_pkg::PPT_IRQ_OC_BIT];

    // supply pin level as software or pwm wants it
    assign supply_high = i_pwm_supply_en ? i_pwm_supply_val
        : out_reg[ppt_pkg::PPT_OUT_SUPPLY_BIT];

    assign monitor_on = misc_reg[ppt_pkg::PPT_MISC_OVERCURRENT_MONITOR_ENABLE_BIT] && !i_stop_mode;

    // over-current flag; a new event wins over a clear in the same cycle
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            oc_flag_reg <= 1'b0;
        end
        else if (monitor_on && misc_reg[ppt_pkg::PPT_MISC_FULLDRV_BIT]
                 && supply_high && i_oc_detect)
        begin
            oc_flag_reg <= 1'b1;
        end
        else if (oc_clr)
        begin
            oc_flag_reg <= 1'b0;
        end
    end

    // supply pin drive outputs
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_supply_drive <= 1'b0;
            o_supply_full_drive <= 1'b0;
            o_oc_monitor_on <= 1'b0;
        end
        else
        begin
            // forced low while flag stands, also on detect itself
            o_supply_drive <= supply_high && !oc_flag_reg && !(monitor_on && i_oc_detect
                && misc_reg[ppt_pkg::PPT_MISC_FULLDRV_BIT]);
            o_supply_full_drive <= misc_reg[ppt_pkg::PPT_MISC_FULLDRV_BIT];
            o_oc_monitor_on <= monitor_on;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_irq <= 1'b0;
        end
        else
        begin
            o_irq <= oc_flag_reg && irq_en_reg[ppt_pkg::PPT_IRQ_OC_BIT];
        end
    end

    // trigger routing: index 1 is channel five, index 0 channel four
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_adc_ext_trigger_in <= 2'h0;
        end
        else
        begin
            for (int t = 0; t < 2; t++)
            begin
                if (i_pwm_route[t].enabled && !i_pwm_route[t].internal)
                begin
                    o_adc_ext_trigger_in[t] <= i_pwm_val[t];
                end
                else if (i_pwm_route[t].alt_pin)
                begin
                    o_adc_ext_trigger_in[t] <= i_pin_alt[t];
                end
                else
                begin
                    o_adc_ext_trigger_in[t] <= i_pin_main[t];
                end
            end
        end
    end

    // high-voltage input buffers and pulls
    always_comb
    begin
        buf_en_next = '1;
        for (int p = 0; p < HV_PINS; p++)
        begin
            if (hv_reg[ppt_pkg::PPT_HV_EN_BIT] && (hv_sel == 2'(p)) && !i_stop_mode
                && !(hv_reg[ppt_pkg::PPT_HV_TEST_BIT] && !hv_reg[ppt_pkg::PPT_HV_DIR_BIT]))
            begin
                buf_en_next[p] = 1'b0;
            end
        end
    end

    // registered buffer enables, pulls and the pad level view
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_hv_buffer_en <= '1;
            o_hv_pullup_en <= '0;
            o_hv_pulldown_en <= '0;
            level_reg <= '0;
        end
        else
        begin
            o_hv_buffer_en <= buf_en_next;
            for (int p = 0; p < HV_PINS; p++)
            begin
                // pull select on the chosen pin
                o_hv_pullup_en[p] <= hv_reg[ppt_pkg::PPT_HV_EN_BIT] && (hv_sel == 2'(p))
                    && hv_reg[ppt_pkg::PPT_HV_PULL_BIT];
                o_hv_pulldown_en[p] <= hv_reg[ppt_pkg::PPT_HV_EN_BIT] && (hv_sel == 2'(p))
                    && !hv_reg[ppt_pkg::PPT_HV_PULL_BIT];
            end
            // level reads pad through enabled buffer
            level_reg <= i_hv_pad & buf_en_next;
        end
    end

    // read mux, data valid in the cycle after the strobe
    always_comb
    begin
        rdata_next = 8'h00;
        unique case (i_req.addr)
            ppt_pkg::PPT_ADDR_MISC: rdata_next = misc_reg;
            ppt_pkg::PPT_ADDR_OUT: rdata_next = out_reg;
            ppt_pkg::PPT_ADDR_HV: rdata_next = hv_reg;
            ppt_pkg::PPT_ADDR_LEVEL: rdata_next = 8'(level_reg);
            ppt_pkg::PPT_ADDR_IRQ_STAT: rdata_next = {7'h00, oc_flag_reg};
            ppt_pkg::PPT_ADDR_IRQ_EN: rdata_next = irq_en_reg;
            ppt_pkg::PPT_ADDR_TRIG: rdata_next = trig_reg;
            // unmapped and write-only addresses read zero
            default: rdata_next = 8'h00;
        endcase
    end

    // read data register, zero outside the cycle after a read
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_rdata <= 8'h00;
        end
        else
        begin
            o_rdata <= i_req.rd ? rdata_next : 8'h00;
        end
    end

    chk_irq_gating: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        o_irq == $past(oc_flag_reg && irq_en_reg[0]))
        else $error("irq does not follow flag and enable");

    chk_drive_forced: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        $past(oc_flag_reg) |-> !o_supply_drive)
        else $error("supply driven while flag set");

    chk_flag_set: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (monitor_on && misc_reg[1] && supply_high && i_oc_detect) |=> oc_flag_reg)
        else $error("over-current not flagged");

    chk_stop_quiet: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (i_stop_mode && !oc_flag_reg) |=> !oc_flag_reg)
        else $error("flag set during stop");

    chk_flag_clear: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (oc_clr && !i_oc_detect) |=> !oc_flag_reg)
        else $error("flag not cleared");

    chk_full_drive: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (!misc_reg[1] && !oc_flag_reg) |=> !oc_flag_reg)
        else $error("flag without full drive");

    chk_trig_pwm: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (i_pwm_route[1].enabled && !i_pwm_route[1].internal)
        |=> o_adc_ext_trigger_in[1] == $past(i_pwm_val[1]))
        else $error("trigger not from pwm");

    chk_override: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (hv_reg[5] && !hv_reg[3]) |=> o_hv_buffer_en == '1)
        else $error("buffer disabled under override");

endmodule : ppt_top

/* File: include/ppt_pkg.sv */
/*
  ppt_pkg: shared constants and carrier types for the port protect, trigger
  route and high-voltage input test block.
  assumes: a single 250 MHz clock domain and a plain strobe register port.
*/
package ppt_pkg;

    // register addresses on the plain register port
    localparam logic [3:0] PPT_ADDR_MISC = 4'h0;       // port_misc_config
    localparam logic [3:0] PPT_ADDR_OUT = 4'h1;        // pin_output_value_reg
    localparam logic [3:0] PPT_ADDR_HV = 4'h2;         // hv_analog_control
    localparam logic [3:0] PPT_ADDR_LEVEL = 4'h3;      // hv_input_level (read only)
    localparam logic [3:0] PPT_ADDR_IRQ_STAT = 4'h4;   // port_p_irq_flags (read only)
    localparam logic [3:0] PPT_ADDR_IRQ_CLR = 4'h5;    // write one to clear
    localparam logic [3:0] PPT_ADDR_IRQ_EN = 4'h6;     // port_p_irq_enables
    localparam logic [3:0] PPT_ADDR_TRIG = 4'h7;       // spare routing bits, read back only

    // field positions
    localparam int PPT_MISC_OVERCURRENT_MONITOR_ENABLE_BIT = 0;     // overcurrent_monitor_enable
    localparam int PPT_MISC_FULLDRV_BIT = 1;  // full drive on supply pin
    localparam int PPT_OUT_SUPPLY_BIT = 2;    // supply_pin_out_value
    localparam int PPT_IRQ_OC_BIT = 0;        // overcurrent_flag position
    localparam int PPT_HV_SEL_LSB = 0;        // hv_pin_select [1:0]
    localparam int PPT_HV_EN_BIT = 2;         // hv_analog_enable
    localparam int PPT_HV_DIR_BIT = 3;        // hv_direct_input_select
    localparam int PPT_HV_PULL_BIT = 4;       // hv_pull_select
    localparam int PPT_HV_TEST_BIT = 5;       // hv_buffer_override

    // reset values
    localparam logic [7:0] PPT_MISC_RST = 8'h00;
    localparam logic [7:0] PPT_OUT_RST = 8'h00;
    localparam logic [7:0] PPT_HV_RST = 8'h00;
    localparam logic [7:0] PPT_IRQ_EN_RST = 8'h00;
    localparam logic [7:0] PPT_TRIG_RST = 8'h00;

    // pwm-side routing info for one trigger channel
    typedef struct packed {
        logic enabled;     // pwm channel running
        logic internal;    // routed for internal use only
        logic alt_pin;     // relocated to the alternative pin
    } ppt_pwm_route_t;

    // register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ppt_reg_req_t;

endpackage : ppt_pkg

/* File: tb/ppt_load_model.sv */
/*
  ppt_load_model: external wiring of the block, a load on the supply pin that
  the bench can short, and optional pull devices on the high-voltage inputs.
  assumes: the bench chooses the short and the external pulls per pin.
*/
`timescale 1ns/10ps
module ppt_load_model (
    input wire logic i_clk,
    input wire logic i_short,
    input wire logic i_drive,
    input wire logic i_full,
    input wire logic [3:0] i_ext_up,
    input wire logic [3:0] i_ext_dn,
    input wire logic [3:0] i_pu_en,
    input wire logic [3:0] i_pd_en,
    output logic o_oc,
    output logic [3:0] o_pad
);
    logic flt_reg = 1'b0; // level of a floating input

    // a floating input wanders each cycle so that no lucky value passes
    always_ff @(posedge i_clk)
    begin
        flt_reg <= ~flt_reg;
    end

    // excess current
    // current only flows into the short while the pin is driven high at full drive
    assign o_oc = i_short & i_drive & i_full;

    // pull resolution
    // an external pull beats the weak internal ones
    always_comb
    begin
        for (int k = 0; k < 4; k++)
        begin
            o_pad[k] = i_ext_up[k] | (~i_ext_dn[k] & (i_pu_en[k] | (~i_pd_en[k] & flt_reg)));
        end
    end
endmodule : ppt_load_model

/* File: tb/ppt_top_bench.sv */
/*
  ppt_top_bench: self-checking bench for supply protection, trigger routing
  and the high-voltage open-input test.
  assumes: one 250 MHz clock; the load model stands on the pins.
*/
`timescale 1ns/10ps
module ppt_top_bench;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    ppt_pkg::ppt_reg_req_t req = '0; // register port request
    logic [7:0] rdata;
    logic stop = 1'b0;
    logic pwm_se = 1'b0; // pwm owns the supply pin
    logic pwm_sv = 1'b1; // pwm level on the supply pin
    logic [1:0] pwm_val = 2'b00;
    ppt_pkg::ppt_pwm_route_t [1:0] route = '0;
    logic [1:0] pin_main = 2'b00;
    logic [1:0] pin_alt = 2'b00;
    logic [3:0] ext_up = 4'h0; // external pullups fitted
    logic [3:0] ext_dn = 4'h0; // external pulldowns fitted
    logic shorted = 1'b0; // supply load short circuit
    logic oc, drive, full, mon_on, irq;
    logic [1:0] trig;
    logic [3:0] pad, buf_en, pu_en, pd_en;
    int n_tests = 0;
    int n_mismatch = 0;
    int cyc = 0;

    ppt_top #(.HV_PINS(4)) u_ppt_top (
        .i_clk(clk), .i_arst_n(arst_n), .i_req(req), .o_rdata(rdata),
        .i_stop_mode(stop), .i_oc_detect(oc), .i_pwm_supply_en(pwm_se),
        .i_pwm_supply_val(pwm_sv), .i_pwm_val(pwm_val), .i_pwm_route(route),
        .i_pin_main(pin_main), .i_pin_alt(pin_alt), .i_hv_pad(pad),
        .o_supply_drive(drive), .o_supply_full_drive(full), .o_oc_monitor_on(mon_on),
        .o_adc_ext_trigger_in(trig), .o_hv_buffer_en(buf_en), .o_hv_pullup_en(pu_en),
        .o_hv_pulldown_en(pd_en), .o_irq(irq));

    ppt_load_model u_ppt_load_model (
        .i_clk(clk), .i_short(shorted), .i_drive(drive), .i_full(full),
        .i_ext_up(ext_up), .i_ext_dn(ext_dn), .i_pu_en(pu_en), .i_pd_en(pd_en),
        .o_oc(oc), .o_pad(pad));

    // free-running clock, 4 ns period
    initial
    begin
        forever #2 clk = ~clk;
    end

    // verdict and end of run
    task automatic summarize;
        $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : summarize

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd

    // outputs are registered levels, a few edges is ample
    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask : settle

    // r = {enabled, internal, alt_pin}, v = {alt pin, main pin, pwm}
    function automatic logic tsel(input logic [2:0] r, input logic [2:0] v);
        return (r[2] & ~r[1]) ? v[0] : (r[0] ? v[2] : v[1]);
    endfunction : tsel

    task automatic t_reset;
        logic [7:0] d;
        // level register skipped: unpulled pads float
        for (int a = 0; a < 16; a++)
        begin
            if (a != 3)
            begin
                rd(a[3:0], d);
                chk(d, 8'h00);
            end
        end
        chk({3'h0, irq, buf_en}, 8'h0F);
    endtask : t_reset

    task automatic t_trig;
        logic [1:0] x;
        // channels get opposite routing so a swap of the two shows
        for (int c = 0; c < 8; c++)
        begin
            for (int v = 0; v < 8; v++)
            begin
                // inputs move right after a rising edge
                @(posedge clk);
                route <= {ppt_pkg::ppt_pwm_route_t'(c[2:0]), ppt_pkg::ppt_pwm_route_t'(~c[2:0])};
                pwm_val <= {2{v[0]}};
                pin_main <= {2{v[1]}};
                pin_alt <= {2{v[2]}};
                settle();
                x = {tsel(c[2:0], v[2:0]), tsel(~c[2:0], v[2:0])};
                chk({6'h00, trig}, {6'h00, x});
            end
        end
    endtask : t_trig

    task automatic t_oc;
        logic [7:0] d;
        logic m, f, o, s, p, v, hi, e;
        wr(ppt_pkg::PPT_ADDR_IRQ_EN, 8'h01);
        // every mix of monitor, full drive, output, stop, pwm owner and pwm level
        for (int i = 0; i < 64; i++)
        begin
            {m, f, o, s, p, v} = i[5:0];
            hi = p ? v : o;
            e = m & f & ~s & hi;
            @(posedge clk);
            stop <= s;
            pwm_se <= p;
            pwm_sv <= v;
            wr(ppt_pkg::PPT_ADDR_MISC, {6'h00, f, m});
            wr(ppt_pkg::PPT_ADDR_OUT, {5'h00, o, 2'b00});
            @(posedge clk);
            shorted <= 1'b1;
            settle();
            rd(ppt_pkg::PPT_ADDR_IRQ_STAT, d);
            chk({d[6:0], irq}, {6'h00, e, e});
            chk({6'h00, mon_on, full}, {6'h00, m & ~s, f});
            @(posedge clk);
            shorted <= 1'b0;
            settle();
            chk({7'h00, drive}, {7'h00, hi & ~e});
            wr(ppt_pkg::PPT_ADDR_IRQ_CLR, 8'h01);
            settle();
            rd(ppt_pkg::PPT_ADDR_IRQ_STAT, d);
            chk({d[6:0], drive}, {7'h00, hi});
        end
        // masked flag, then enabled, then cleared
        @(posedge clk);
        stop <= 1'b0;
        pwm_se <= 1'b0;
        wr(ppt_pkg::PPT_ADDR_IRQ_EN, 8'h00);
        wr(ppt_pkg::PPT_ADDR_OUT, 8'h04);
        wr(ppt_pkg::PPT_ADDR_MISC, 8'h03);
        @(posedge clk);
        shorted <= 1'b1;
        settle();
        wr(ppt_pkg::PPT_ADDR_IRQ_STAT, 8'h00);
        rd(ppt_pkg::PPT_ADDR_IRQ_STAT, d);
        chk({d[6:0], irq}, 8'h02);
        wr(ppt_pkg::PPT_ADDR_IRQ_EN, 8'h01);
        settle();
        chk({7'h00, irq}, 8'h01);
        @(posedge clk);
        shorted <= 1'b0;
        wr(ppt_pkg::PPT_ADDR_IRQ_CLR, 8'h01);
        settle();
        chk({6'h00, irq, drive}, 8'h01);
        wr(ppt_pkg::PPT_ADDR_OUT, 8'h00);
        @(posedge clk);
        stop <= 1'b1;
        settle();
        chk({6'h00, mon_on, drive}, 8'h00);
        @(posedge clk);
        stop <= 1'b0;
    endtask : t_oc

    task automatic t_hv;
        logic [7:0] d;
        logic [7:0] hv;
        logic [1:0] k;
        logic ps;
        // i: [1:0] pin, [2] pull select, [3] external pull fitted
        for (int i = 0; i < 16; i++)
        begin
            k = i[1:0];
            ps = i[2];
            @(posedge clk);
            ext_up <= (i[3] & ~i[2]) ? 4'h1 << i[1:0] : 4'h0;
            ext_dn <= (i[3] & i[2]) ? 4'h1 << i[1:0] : 4'h0;
            hv = {2'b00, 1'b1, i[2], 1'b0, 1'b1, i[1:0]};
            wr(ppt_pkg::PPT_ADDR_HV, hv);
            settle();
            rd(ppt_pkg::PPT_ADDR_LEVEL, d);
            chk({7'h00, d[k]}, {7'h00, i[2] ^ i[3]});
            chk({5'h00, buf_en[k], pu_en[k], pd_en[k]}, {5'h00, 1'b1, ps, ~ps});
            // override has no effect in direct mode
            wr(ppt_pkg::PPT_ADDR_HV, hv | 8'h08);
            settle();
            chk({7'h00, buf_en[k]}, 8'h00);
            wr(ppt_pkg::PPT_ADDR_HV, hv & 8'hDF);
            settle();
            rd(ppt_pkg::PPT_ADDR_LEVEL, d);
            chk({6'h00, buf_en[k], d[k]}, 8'h00);
        end
        wr(ppt_pkg::PPT_ADDR_HV, 8'h04);
        settle();
        chk({4'h0, buf_en}, 8'h0E);
    endtask : t_hv

    // hang guard, well above the few thousand cycles needed
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_mismatch = n_mismatch + 1;
            summarize();
        end
    end

    initial
    begin
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_trig();
        t_oc();
        t_hv();
        summarize();
    end
endmodule : ppt_top_bench
